// ### cevn_host_sink.sv
// Packet sink standing in for the host event receiver
`timescale 1ns/1ns
`default_nettype none
module cevn_host_sink (
    input  wire logic i_core_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_slow,
    output var  logic o_ready
);
    // Slow mode stalls at random so held packets get exercised
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst)
            o_ready <= 1'b0;
        else
            o_ready <= i_slow ? 1'($urandom) : 1'b1;
    end
endmodule : cevn_host_sink
`default_nettype wire

// ### cevn_notifier.sv
// Camera event notifier: event detection, timestamps, packets, APB regs
`timescale 1ns/1ns
`default_nettype none
`include "cevn_params.svh"

module cevn_notifier #(
    parameter int NUM_EVENTS = `CEVN_NUM_EVENTS,
    parameter int TS_WIDTH   = 64
) (
    input  wire logic                      i_core_clk,
    input  wire logic                      i_sys_rst,
    input  wire logic                      i_clk_en,
    // Event strobes, one cycle each, bit order as the identifier table
    input  wire logic [NUM_EVENTS-1:0]     i_event_pulse,
    // APB slave
    input  wire logic                      i_psel,
    input  wire logic                      i_penable,
    input  wire logic                      i_pwrite,
    input  wire logic [11:0]               i_paddr,
    input  wire logic [31:0]               i_pwdata,
    output var  logic [31:0]               o_prdata,
    output var  logic                      o_pready,
    output var  logic                      o_pslverr,
    // Packet toward the link framer
    output var  logic                      o_pkt_valid,
    input  wire logic                      i_pkt_ready,
    output var  cevn_pkg::cevn_packet_s    o_pkt,
    output var  logic                      o_irq
);

    initial begin
        if (NUM_EVENTS != `CEVN_NUM_EVENTS || TS_WIDTH != 64) begin
            $error("cevn_notifier: unsupported parameters");
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] event_id(input logic [3:0] idx);
        case (idx)
            4'h0:    event_id = `CEVN_ID_TRIG_ACC;
            4'h1:    event_id = `CEVN_ID_TRIG_REJ;
            4'h2:    event_id = `CEVN_ID_TRIG_WAIT;
            4'h3:    event_id = `CEVN_ID_XFER_BEG;
            4'h4:    event_id = `CEVN_ID_XFER_END;
            4'h5:    event_id = `CEVN_ID_EXP_BEG;
            4'h6:    event_id = `CEVN_ID_EXP_END;
            4'h7:    event_id = `CEVN_ID_TMR_BEG;
            4'h8:    event_id = `CEVN_ID_TMR_END;
            default: event_id = 16'h0000;
        endcase
    endfunction : event_id

    function automatic logic [3:0] lowest_set(input logic [8:0] v);
        lowest_set = 4'h0;
        for (int i = 8; i >= 0; i--) begin
            if (v[i]) begin
                lowest_set = 4'(i);
            end
        end
    endfunction : lowest_set

    // ****************************************
    // State
    // ****************************************
    logic [TS_WIDTH-1:0]   ts_cnt_q;
    logic [TS_WIDTH-1:0]   ts_q [NUM_EVENTS];
    logic [3:0]            sel_q;
    logic [NUM_EVENTS-1:0] en_q;
    logic [NUM_EVENTS-1:0] pend_q;
    logic [NUM_EVENTS-1:0] status_q;
    logic [NUM_EVENTS-1:0] mask_q;
    logic [31:0]           ts_hi_latch_q;
    cevn_pkg::cevn_state_e state_q;
    logic [3:0]            sent_q;

    logic                  access;
    logic                  wr;
    logic                  rd;
    logic [3:0]            ts_idx;
    logic                  ts_hit;
    logic [NUM_EVENTS-1:0] pend_clr;
    logic [3:0]            pick;

    assign access = i_clk_en && i_psel && i_penable && o_pready;
    assign wr     = access && i_pwrite;
    assign rd     = access && !i_pwrite;
    assign ts_hit = i_paddr >= `CEVN_OFS_TS_BASE
                 && i_paddr <= `CEVN_OFS_TS_LAST
                 && i_paddr[1:0] == 2'b00;
    assign ts_idx = 4'((i_paddr - `CEVN_OFS_TS_BASE) >> 3);
    assign pick   = lowest_set(pend_q);

    // ****************************************
    // Timestamp counter and capture
    // ****************************************
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            ts_cnt_q <= `CEVN_TS_RESET;
        end else if (i_clk_en) begin
            ts_cnt_q <= ts_cnt_q + 1'b1;
        end
    end

    // Captured regardless of enable, so software can poll timestamps
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            for (int i = 0; i < NUM_EVENTS; i++) begin
                ts_q[i] <= `CEVN_TS_RESET;
            end
        end else if (i_clk_en) begin
            for (int i = 0; i < NUM_EVENTS; i++) begin
                if (i_event_pulse[i]) begin
                    ts_q[i] <= ts_cnt_q;
                end
            end
        end
    end

    // ****************************************
    // Selection and per-type enables
    // ****************************************
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            sel_q <= `CEVN_SEL_RESET;
        end else if (wr && i_paddr == `CEVN_OFS_SELECT
                     && i_pwdata[3:0] < 4'(NUM_EVENTS)) begin
            sel_q <= i_pwdata[3:0];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            en_q <= `CEVN_EN_RESET;
        end else if (wr && i_paddr == `CEVN_OFS_ENABLE) begin
            en_q[sel_q] <= i_pwdata[0];
        end
    end

    // ****************************************
    // Pending packets
    // ****************************************
    // One pending flag per type; a repeat before send merges, the
    // timestamp still shows the latest occurrence
    always_comb begin
        pend_clr = '0;
        if (state_q == cevn_pkg::CEVN_ST_DATA && i_pkt_ready) begin
            pend_clr[sent_q] = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            pend_q <= '0;
        end else if (i_clk_en) begin
            // Set wins over clear
            pend_q <= (pend_q & ~pend_clr) | (i_event_pulse & en_q);
        end
    end

    // ****************************************
    // Packet sender
    // ****************************************
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state_q     <= cevn_pkg::CEVN_ST_IDLE;
            o_pkt_valid <= 1'b0;
            o_pkt       <= '0;
            sent_q      <= '0;
        end else if (i_clk_en) begin
            case (state_q)
                cevn_pkg::CEVN_ST_IDLE: begin
                    if (|pend_q) begin
                        state_q <= cevn_pkg::CEVN_ST_HEAD;
                    end
                end
                cevn_pkg::CEVN_ST_HEAD: begin
                    o_pkt.event_id  <= event_id(pick);
                    o_pkt.timestamp <= ts_q[pick];
                    // Held, so a lower pulse meanwhile keeps its own flag
                    sent_q          <= pick;
                    o_pkt_valid     <= 1'b1;
                    state_q         <= cevn_pkg::CEVN_ST_DATA;
                end
                cevn_pkg::CEVN_ST_DATA: begin
                    if (i_pkt_ready) begin
                        o_pkt_valid <= 1'b0;
                        state_q     <= cevn_pkg::CEVN_ST_IDLE;
                    end
                end
                default: begin
                    o_pkt_valid <= 1'b0;
                    state_q     <= cevn_pkg::CEVN_ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Interrupt status and mask
    // ****************************************
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            status_q <= '0;
        end else if (i_clk_en) begin
            if (rd && i_paddr == `CEVN_OFS_STATUS) begin
                status_q <= i_event_pulse;
            end else begin
                status_q <= status_q | i_event_pulse;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            mask_q <= `CEVN_MASK_RESET;
        end else if (wr && i_paddr == `CEVN_OFS_MASK) begin
            mask_q <= i_pwdata[NUM_EVENTS-1:0];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_irq <= 1'b0;
        end else if (i_clk_en) begin
            o_irq <= |(status_q & mask_q);
        end
    end

    // ****************************************
    // APB read path
    // ****************************************
    // Low read of the live counter latches the high half for coherence
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            ts_hi_latch_q <= '0;
        end else if (rd && i_paddr == `CEVN_OFS_TS_LO) begin
            ts_hi_latch_q <= ts_cnt_q[63:32];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_pready  <= 1'b0;
            o_prdata  <= '0;
            o_pslverr <= 1'b0;
        end else if (i_clk_en) begin
            o_pready  <= i_psel && !i_penable;
            o_prdata  <= '0;
            o_pslverr <= 1'b0;
            if (i_psel && !i_penable && !i_pwrite) begin
                if (ts_hit) begin
                    o_prdata <= i_paddr[2] ? ts_q[ts_idx][63:32]
                                           : ts_q[ts_idx][31:0];
                end else begin
                    case (i_paddr)
                        `CEVN_OFS_SELECT: o_prdata <= {28'h0, sel_q};
                        `CEVN_OFS_ENABLE: o_prdata <= 32'(en_q[sel_q]);
                        `CEVN_OFS_STATUS: o_prdata <= {23'h0, status_q};
                        `CEVN_OFS_MASK:   o_prdata <= {23'h0, mask_q};
                        `CEVN_OFS_TS_LO:  o_prdata <= ts_cnt_q[31:0];
                        `CEVN_OFS_TS_HI:  o_prdata <= ts_hi_latch_q;
                        default:          o_pslverr <= 1'b1;
                    endcase
                end
            end else if (i_psel && !i_penable) begin
                o_pslverr <= !(i_paddr == `CEVN_OFS_SELECT
                            || i_paddr == `CEVN_OFS_ENABLE
                            || i_paddr == `CEVN_OFS_MASK);
            end
        end
    end

endmodule : cevn_notifier

`default_nettype wire

// ### cevn_notifier_chk.sv
// Port checker for the camera event notifier
`timescale 1ns/1ns
`default_nettype none
module cevn_notifier_chk (
    input wire logic                   i_core_clk,
    input wire logic                   i_sys_rst,
    input wire logic                   i_clk_en,
    input wire logic                   i_psel,
    input wire logic                   i_penable,
    input wire logic                   i_pwrite,
    input wire logic [11:0]            i_paddr,
    input wire logic [31:0]            o_prdata,
    input wire logic                   o_pready,
    input wire logic                   o_pslverr,
    input wire logic                   o_pkt_valid,
    input wire logic                   i_pkt_ready,
    input wire cevn_pkg::cevn_packet_s o_pkt,
    input wire logic                   o_irq
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst || !i_clk_en);
    wire logic setup = i_psel && !i_penable;
    property p_ans; setup |=> o_pready; endproperty
    property p_quiet; !i_psel |=> !o_pready; endproperty
    property p_err0; o_pslverr |-> o_prdata == 32'h0; endproperty
    property p_unmap; setup && i_paddr == 12'h020 |=> o_pslverr; endproperty
    property p_ro;
        setup && i_pwrite && i_paddr == 12'h040 |=> o_pslverr;
    endproperty
    property p_id;
        o_pkt_valid |-> o_pkt.event_id inside {16'h8020, 16'h8021,
            16'h8022, 16'h8030, 16'h8031, 16'h8040, 16'h8041, 16'h9000,
            16'h9100};
    endproperty
    property p_hold;
        o_pkt_valid && !i_pkt_ready |=> o_pkt_valid && $stable(o_pkt);
    endproperty
    property p_gap;
        o_pkt_valid && i_pkt_ready |=> !o_pkt_valid [*2];
    endproperty
    a_ans: assert property (p_ans) else $error("no answer after setup");
    a_quiet: assert property (p_quiet) else $error("stray ready");
    a_err0: assert property (p_err0) else $error("error with data");
    a_unmap: assert property (p_unmap) else $error("unmapped no error");
    a_ro: assert property (p_ro) else $error("timestamp write taken");
    a_id: assert property (p_id) else $error("bad event id");
    a_hold: assert property (p_hold) else $error("packet not held");
    a_gap: assert property (p_gap) else $error("packet gap short");
    c_pkt: cover property (o_pkt_valid && i_pkt_ready);
    c_err: cover property (o_pslverr);
    c_irq: cover property (o_irq);
endmodule : cevn_notifier_chk
bind cevn_notifier cevn_notifier_chk cevn_notifier_chk_i (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_pkt_valid(o_pkt_valid), .i_pkt_ready(i_pkt_ready), .o_pkt(o_pkt),
    .o_irq(o_irq));
`default_nettype wire

// ### cevn_notifier_test.sv
// Self-checking bench for the camera event notifier
`timescale 1ns/1ns
`default_nettype none
module cevn_notifier_test;
    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    logic                   slow = 1'b0;
    logic                   en = 1'b1;
    int                     c;
    logic                   psel = 1'b0;
    logic                   pen = 1'b0;
    logic                   pwr = 1'b0;
    logic [8:0]             ev = 9'h0;
    logic [8:0]             v;
    logic [11:0]            paddr = 12'h0;
    logic [31:0]            pwdata = 32'h0;
    logic [31:0]            prdata, rd;
    logic                   pready, pslverr, pvalid, prdy, irq, err;
    cevn_pkg::cevn_packet_s pkt;
    int                     failures = 0;
    int                     checks_done = 0;
    int                     cyc = 0;
    int                     at [9];
    logic [15:0]            ids [9] = '{16'h8020, 16'h8021, 16'h8022,
        16'h8030, 16'h8031, 16'h8040, 16'h8041, 16'h9000, 16'h9100};
    logic [15:0]            exp_q [$];
    logic [15:0]            got_q [$];
    logic [63:0]            got_ts [$];
    logic [63:0]            ts0, tsk;

    always #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    always @(posedge clk) begin
        if (pvalid === 1'b1 && prdy === 1'b1 && en === 1'b1) begin
            got_q.push_back(pkt.event_id);
            got_ts.push_back(pkt.timestamp);
        end
    end

    cevn_notifier cevn_notifier_i (
        .i_core_clk(clk), .i_sys_rst(rst), .i_clk_en(en),
        .i_event_pulse(ev), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_pkt_valid(pvalid), .i_pkt_ready(prdy), .o_pkt(pkt),
        .o_irq(irq));
    cevn_host_sink cevn_host_sink_i (.i_core_clk(clk), .i_sys_rst(rst),
        .i_slow(slow), .o_ready(prdy));

    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) failures++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic rd_ts(input int k);
        apb(1'b0, 12'h040 + 12'(8 * k), 32'h0);
        tsk[31:0] = rd;
        apb(1'b0, 12'h044 + 12'(8 * k), 32'h0);
        tsk[63:32] = rd;
    endtask : rd_ts

    task automatic fire(input logic [8:0] p);
        ev <= p;
        for (int k = 0; k < 9; k++) if (p[k]) at[k] = cyc;
        @(posedge clk);
        ev <= 9'h0;
    endtask : fire

    task automatic drain();
        int n;
        n = 0;
        while (got_q.size() < exp_q.size() && n < 200) begin
            @(posedge clk);
            n++;
        end
        repeat (6) @(posedge clk);
        chk(64'(got_q.size()), 64'(exp_q.size()));
        while (exp_q.size() > 0 && got_q.size() > 0)
            chk(64'(got_q.pop_front()), 64'(exp_q.pop_front()));
        got_q.delete();
        exp_q.delete();
    endtask : drain

    task automatic complete_run();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    initial begin
        #3000000;
        failures++;
        complete_run();
    end

    // ****
    // Tests
    // ****
    initial begin
        void'($urandom(70));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, 12'h000, 32'h0);
        chk(64'(rd), 64'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(64'(rd), 64'h0);
        for (int k = 0; k < 9; k++) begin
            apb(1'b1, 12'h000, 32'(k));
            apb(1'b1, 12'h004, 32'(k != 3));
        end
        apb(1'b1, 12'h000, 32'h9);
        apb(1'b0, 12'h000, 32'h0);
        chk(64'(rd), 64'h8);
        apb(1'b0, 12'h004, 32'h0);
        chk(64'(rd), 64'h1);
        apb(1'b1, 12'h000, 32'h3);
        apb(1'b0, 12'h004, 32'h0);
        chk(64'(rd), 64'h0);
        $display("register test done");
        for (int k = 0; k < 9; k++) begin
            fire(9'h1 << k);
            if (k != 3) exp_q.push_back(ids[k]);
            drain();
            rd_ts(k);
            if (k == 0) ts0 = tsk;
            chk(tsk - ts0, 64'(at[k] - at[0]));
            if (k != 3) chk(got_ts.pop_front(), tsk);
        end
        $display("event test done");
        apb(1'b1, 12'h00c, 32'h1ff);
        @(posedge clk);
        chk(64'(irq), 64'h1);
        apb(1'b0, 12'h008, 32'h0);
        chk(64'(rd), 64'h1ff);
        @(posedge clk);
        chk(64'(irq), 64'h0);
        fire(9'h010);
        exp_q.push_back(ids[4]);
        repeat (2) @(posedge clk);
        chk(64'(irq), 64'h1);
        drain();
        apb(1'b1, 12'h00c, 32'h0);
        @(posedge clk);
        chk(64'(irq), 64'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk(64'(rd), 64'h010);
        $display("interrupt test done");
        apb(1'b0, 12'h020, 32'h0);
        chk(64'({err, rd}), 64'h1_0000_0000);
        apb(1'b1, 12'h040, 32'h5);
        chk(64'(err), 64'h1);
        rd_ts(0);
        chk(tsk, ts0);
        // Live counter runs one count per clock from the first capture
        c = cyc;
        apb(1'b0, 12'h010, 32'h0);
        chk(64'(rd) - ts0, 64'(c - at[0]));
        apb(1'b0, 12'h014, 32'h0);
        chk(64'(rd), ts0 >> 32);
        // Pulse while frozen must leave no packet and no status
        en <= 1'b0;
        fire(9'h002);
        repeat (2) @(posedge clk);
        en <= 1'b1;
        drain();
        apb(1'b0, 12'h008, 32'h0);
        chk(64'(rd), 64'h0);
        $display("error test done");
        slow <= 1'b1;
        for (int r = 0; r < 6; r++) begin
            v = 9'($urandom) | 9'h001;
            for (int k = 0; k < 9; k++)
                if (v[k] && k != 3) exp_q.push_back(ids[k]);
            fire(v);
            drain();
        end
        $display("random test done");
        complete_run();
    end
endmodule : cevn_notifier_test
`default_nettype wire

// ### cevn_params.svh
// Constants for the camera event notifier: offsets, identifiers, reset values, sizes
`ifndef CEVN_PARAMS_SVH
`define CEVN_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define CEVN_OFS_SELECT   12'h000
`define CEVN_OFS_ENABLE   12'h004
`define CEVN_OFS_STATUS   12'h008
`define CEVN_OFS_MASK     12'h00c
`define CEVN_OFS_TS_LO    12'h010
`define CEVN_OFS_TS_HI    12'h014
`define CEVN_OFS_TS_BASE  12'h040
`define CEVN_OFS_TS_LAST  12'h084

// ****************************************
// Event identifiers
// ****************************************
`define CEVN_ID_TRIG_ACC  16'h8020
`define CEVN_ID_TRIG_REJ  16'h8021
`define CEVN_ID_TRIG_WAIT 16'h8022
`define CEVN_ID_XFER_BEG  16'h8030
`define CEVN_ID_XFER_END  16'h8031
`define CEVN_ID_EXP_BEG   16'h8040
`define CEVN_ID_EXP_END   16'h8041
`define CEVN_ID_TMR_BEG   16'h9000
`define CEVN_ID_TMR_END   16'h9100

// ****************************************
// Reset values and sizes
// ****************************************
`define CEVN_NUM_EVENTS   9
`define CEVN_SEL_RESET    4'h0
`define CEVN_EN_RESET     9'h000
`define CEVN_MASK_RESET   9'h000
`define CEVN_TS_RESET     64'h0

`endif

// ### cevn_pkg.sv
// Types shared by the camera event notifier
package cevn_pkg;

    typedef enum logic [2:0] {
        CEVN_ST_IDLE = 3'b001,
        CEVN_ST_HEAD = 3'b010,
        CEVN_ST_DATA = 3'b100
    } cevn_state_e;

    // One outgoing event packet word pair: identifier plus timestamp
    typedef struct packed {
        logic [15:0] event_id;
        logic [63:0] timestamp;
    } cevn_packet_s;

endpackage : cevn_pkg
